/* rtl/lcce_pkg.sv */
// Package with opcodes, form codes, lengths and cycle counts for the logic/compare/clear unit
package lcce_pkg;

  // Decoded instruction forms
  typedef enum logic [4:0] {
    LCCE_F_NONE      = 5'b00000,
    LCCE_F_ANL_A_RN  = 5'b00001,
    LCCE_F_ANL_A_DIR = 5'b00010,
    LCCE_F_ANL_A_IND = 5'b00011,
    LCCE_F_ANL_A_IMM = 5'b00100,
    LCCE_F_ANL_D_A   = 5'b00101,
    LCCE_F_ANL_D_IMM = 5'b00110,
    LCCE_F_ANL_C_BIT = 5'b00111,
    LCCE_F_ANL_C_NB  = 5'b01000,
    LCCE_F_CJ_A_DIR  = 5'b01001,
    LCCE_F_CJ_A_IMM  = 5'b01010,
    LCCE_F_CJ_RN_IMM = 5'b01011,
    LCCE_F_CJ_IN_IMM = 5'b01100,
    LCCE_F_CLR_A     = 5'b01101,
    LCCE_F_CLR_C     = 5'b01110,
    LCCE_F_CLR_BIT   = 5'b01111,
    LCCE_F_CPL_A     = 5'b10000,
    LCCE_F_CPL_C     = 5'b10001,
    LCCE_F_CPL_BIT   = 5'b10010
  } lcce_form_type;

  // Sequencer states
  typedef enum logic [1:0] {
    LCCE_S_IDLE = 2'b00,
    LCCE_S_WAIT = 2'b01
  } lcce_state_type;

  // Exact opcodes
  localparam logic [7:0] LCCE_OP_ANL_A_DIR = 8'h55;
  localparam logic [7:0] LCCE_OP_ANL_A_IMM = 8'h54;
  localparam logic [7:0] LCCE_OP_ANL_D_A = 8'h52;
  localparam logic [7:0] LCCE_OP_ANL_D_IMM = 8'h53;
  localparam logic [7:0] LCCE_OP_ANL_C_BIT = 8'h82;
  localparam logic [7:0] LCCE_OP_ANL_C_NB = 8'hb0;
  localparam logic [7:0] LCCE_OP_CJ_A_DIR = 8'hb5;
  localparam logic [7:0] LCCE_OP_CJ_A_IMM = 8'hb4;
  localparam logic [7:0] LCCE_OP_CLR_A = 8'he4;
  localparam logic [7:0] LCCE_OP_CLR_C = 8'hc3;
  localparam logic [7:0] LCCE_OP_CLR_BIT = 8'hc2;
  localparam logic [7:0] LCCE_OP_CPL_A = 8'hf4;
  localparam logic [7:0] LCCE_OP_CPL_C = 8'hb3;
  localparam logic [7:0] LCCE_OP_CPL_BIT = 8'hb2;

  // Opcode groups with a register field
  localparam logic [4:0] LCCE_OP_ANL_A_RN_HI = 5'h0b;
  localparam logic [6:0] LCCE_OP_ANL_A_IND_HI = 7'h2b;
  localparam logic [4:0] LCCE_OP_CJ_RN_HI = 5'h17;
  localparam logic [6:0] LCCE_OP_CJ_IN_HI = 7'h5b;

  // Instruction lengths in bytes
  localparam logic [1:0] LCCE_LEN_1 = 2'd1;
  localparam logic [1:0] LCCE_LEN_2 = 2'd2;
  localparam logic [1:0] LCCE_LEN_3 = 2'd3;

  // Execution cycles
  localparam logic [1:0] LCCE_CYC_1 = 2'd1;
  localparam logic [1:0] LCCE_CYC_2 = 2'd2;

  // Reset values
  localparam logic [7:0] LCCE_BYTE_RST = 8'h00;
  localparam logic [15:0] LCCE_PC_RST = 16'h0000;

endpackage : lcce_pkg

/* rtl/lcce_decode.sv */
// Opcode decoder for the logic/compare/clear unit
`timescale 1ns/1ps
module lcce_decode
  import lcce_pkg::*;
(
  input wire logic [7:0] opcode,
  output lcce_form_type form,
  output logic [1:0] length,
  output logic [1:0] cycles,
  output logic conflict,
  output logic legal
);

  // Group matches for forms carrying a register number
  wire logic is_anl_rn = (opcode[7:3] == LCCE_OP_ANL_A_RN_HI);
  wire logic is_anl_ind = (opcode[7:1] == LCCE_OP_ANL_A_IND_HI);
  wire logic is_cj_rn = (opcode[7:3] == LCCE_OP_CJ_RN_HI);
  wire logic is_cj_ind = (opcode[7:1] == LCCE_OP_CJ_IN_HI);

  // [RULE21] Operation over encoding
  // Printed encodings of compare A,#data, compare @Ri and AND C,/bit clash with others;
  // the operation decides and the decode is flagged for review.
  assign conflict = (opcode == LCCE_OP_CJ_A_IMM) || is_cj_ind || (opcode == LCCE_OP_ANL_C_NB);
  assign legal = (form != LCCE_F_NONE);

  // Form, length and cycle count
  always_comb begin
    form = LCCE_F_NONE;
    length = LCCE_LEN_1;
    cycles = LCCE_CYC_1;
    if (is_anl_rn) begin
      // [RULE4] Register source one byte
      form = LCCE_F_ANL_A_RN;
    end else if (is_anl_ind) begin
      form = LCCE_F_ANL_A_IND;
    end else if (is_cj_rn) begin
      // [RULE16] Register number low bits
      form = LCCE_F_CJ_RN_IMM;
      length = LCCE_LEN_3;
      cycles = LCCE_CYC_2;
    end else if (is_cj_ind) begin
      form = LCCE_F_CJ_IN_IMM;
      length = LCCE_LEN_3;
      cycles = LCCE_CYC_2;
    end else begin
      case (opcode)
        LCCE_OP_ANL_A_DIR: begin
          form = LCCE_F_ANL_A_DIR;
          length = LCCE_LEN_2;
        end
        // [RULE5] Accumulator immediate AND
        LCCE_OP_ANL_A_IMM: begin
          form = LCCE_F_ANL_A_IMM;
          length = LCCE_LEN_2;
        end
        // [RULE6] Direct with accumulator
        LCCE_OP_ANL_D_A: begin
          form = LCCE_F_ANL_D_A;
          length = LCCE_LEN_2;
        end
        // [RULE7] Direct with mask
        LCCE_OP_ANL_D_IMM: begin
          form = LCCE_F_ANL_D_IMM;
          length = LCCE_LEN_3;
          cycles = LCCE_CYC_2;
        end
        // [RULE10] Carry AND bit
        LCCE_OP_ANL_C_BIT: begin
          form = LCCE_F_ANL_C_BIT;
          length = LCCE_LEN_2;
          cycles = LCCE_CYC_2;
        end
        LCCE_OP_ANL_C_NB: begin
          form = LCCE_F_ANL_C_NB;
          length = LCCE_LEN_2;
          cycles = LCCE_CYC_2;
        end
        // [RULE15] Compare forms three bytes
        LCCE_OP_CJ_A_DIR: begin
          form = LCCE_F_CJ_A_DIR;
          length = LCCE_LEN_3;
          cycles = LCCE_CYC_2;
        end
        LCCE_OP_CJ_A_IMM: begin
          form = LCCE_F_CJ_A_IMM;
          length = LCCE_LEN_3;
          cycles = LCCE_CYC_2;
        end
        // [RULE17] Clear accumulator
        LCCE_OP_CLR_A: form = LCCE_F_CLR_A;
        // [RULE18] Clear carry or bit
        LCCE_OP_CLR_C: form = LCCE_F_CLR_C;
        LCCE_OP_CLR_BIT: begin
          form = LCCE_F_CLR_BIT;
          length = LCCE_LEN_2;
        end
        // [RULE19] Complement accumulator
        LCCE_OP_CPL_A: form = LCCE_F_CPL_A;
        // [RULE20] Complement carry or bit
        LCCE_OP_CPL_C: form = LCCE_F_CPL_C;
        LCCE_OP_CPL_BIT: begin
          form = LCCE_F_CPL_BIT;
          length = LCCE_LEN_2;
        end
        default: form = LCCE_F_NONE;
      endcase
    end
  end

endmodule : lcce_decode

/* rtl/lcce_exec.sv */
// Execute unit for byte/bit AND, compare-and-branch, clear and complement
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Byte AND to destination, flags untouched
// [RULE2] Six operand forms for byte AND
// [RULE3] Port read-modify-write uses output latch
// [RULE4] Register/indirect one byte, direct two
// [RULE5] Accumulator-immediate AND opcode, two bytes
// [RULE6] Direct-accumulator AND stores to direct
// [RULE7] Direct-mask AND three bytes, two cycles
// [RULE8] Zero source bit clears carry only
// [RULE9] Inverted source uses complement, bit unchanged
// [RULE10] Carry-AND-bit two bytes, two cycles
// [RULE11] Compare branches only when unequal
// [RULE12] Target is advanced PC plus displacement
// [RULE13] Carry set when first below second
// [RULE14] Accumulator, register, indirect compare combinations
// [RULE15] Compare three bytes, two cycles, PC+3
// [RULE16] Register compare number in low bits
// [RULE17] Clear accumulator, one byte, flags kept
// [RULE18] Clear carry or addressable bit
// [RULE19] Complement accumulator, flags kept
// [RULE20] Complement carry or addressable bit
// [RULE21] Conflicting encodings follow operation, flagged
module lcce_exec
  import lcce_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int PC_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic carry_in,
  input wire logic [DATA_W-1:0] reg_in,
  input wire logic [DATA_W-1:0] ind_in,
  input wire logic [DATA_W-1:0] dir_pin_in,
  input wire logic [DATA_W-1:0] dir_latch_in,
  input wire logic dir_is_port,
  input wire logic bit_pin_in,
  input wire logic bit_latch_in,
  input wire logic bit_is_port,
  output logic busy_r,
  output logic done_r,
  output logic illegal_r,
  output logic conflict_r,
  output logic acc_we_r,
  output logic [DATA_W-1:0] acc_wdata_r,
  output logic carry_we_r,
  output logic carry_wdata_r,
  output logic dir_we_r,
  output logic [7:0] dir_addr_r,
  output logic [DATA_W-1:0] dir_wdata_r,
  output logic bit_we_r,
  output logic [7:0] bit_addr_r,
  output logic bit_wdata_r,
  output logic branch_r,
  output logic [PC_W-1:0] pc_next_r
);

  // Pick the read-back source; ports must read their latch, not the pads
  function automatic logic [DATA_W-1:0] lcce_rmw_src(input logic [DATA_W-1:0] pin_v,
                                                    input logic [DATA_W-1:0] latch_v,
                                                    input logic is_port);
    lcce_rmw_src = is_port ? latch_v : pin_v;
  endfunction : lcce_rmw_src

  // Decoder outputs
  lcce_form_type form;
  logic [1:0] length;
  logic [1:0] cycles;
  logic conflict;
  logic legal;

  lcce_decode u_decode (
    .opcode(opcode),
    .form(form),
    .length(length),
    .cycles(cycles),
    .conflict(conflict),
    .legal(legal)
  );

  // Sequencer state
  lcce_state_type state_r;
  lcce_state_type state_nxt;

  // [RULE3] Latch read for ports
  wire logic [DATA_W-1:0] dir_val = lcce_rmw_src(dir_pin_in, dir_latch_in, dir_is_port);
  wire logic [DATA_W-1:0] bit_vec = lcce_rmw_src({{(DATA_W-1){1'b0}}, bit_pin_in},
                                                 {{(DATA_W-1){1'b0}}, bit_latch_in}, bit_is_port);
  wire logic bit_val = bit_vec[0];

  // Immediate widened to data width
  wire logic [DATA_W-1:0] imm2 = DATA_W'(byte2);
  wire logic [DATA_W-1:0] imm3 = DATA_W'(byte3);

  // [RULE2] Source select for accumulator AND
  wire logic [DATA_W-1:0] anl_src = (form == LCCE_F_ANL_A_RN) ? reg_in :
                                    (form == LCCE_F_ANL_A_DIR) ? dir_val :
                                    (form == LCCE_F_ANL_A_IND) ? ind_in : imm2;
  // [RULE1] Bitwise AND results
  wire logic [DATA_W-1:0] anl_acc = acc_in & anl_src;
  // [RULE7] Mask zeros clear bits
  wire logic [DATA_W-1:0] anl_dir = (form == LCCE_F_ANL_D_A) ? (dir_val & acc_in) : (dir_val & imm3);

  // [RULE14] Compare operand pairs
  wire logic [DATA_W-1:0] cmp_a = (form == LCCE_F_CJ_RN_IMM) ? reg_in :
                                  (form == LCCE_F_CJ_IN_IMM) ? ind_in : acc_in;
  wire logic [DATA_W-1:0] cmp_b = (form == LCCE_F_CJ_A_DIR) ? dir_val : imm2;
  // [RULE13] Unsigned less-than to carry
  wire logic cmp_lt = (cmp_a < cmp_b);
  // [RULE11] Branch only when unequal
  wire logic cmp_ne = (cmp_a != cmp_b);

  // Compare form group
  wire logic is_cmp = (form == LCCE_F_CJ_A_DIR) || (form == LCCE_F_CJ_A_IMM) ||
                      (form == LCCE_F_CJ_RN_IMM) || (form == LCCE_F_CJ_IN_IMM);
  // [RULE9] Inverted source bit
  wire logic bit_src = (form == LCCE_F_ANL_C_NB) ? ~bit_val : bit_val;

  // [RULE15] PC advanced by length first
  wire logic [PC_W-1:0] pc_seq = pc_in + PC_W'(length);
  // [RULE12] Signed displacement added
  wire logic [PC_W-1:0] pc_tgt = pc_seq + PC_W'(signed'(byte3));
  wire logic take_branch = is_cmp && cmp_ne;

  // Next values of the result set, computed from the start cycle inputs
  logic acc_we_nxt;
  logic [DATA_W-1:0] acc_wdata_nxt;
  logic carry_we_nxt;
  logic carry_wdata_nxt;
  logic dir_we_nxt;
  logic [DATA_W-1:0] dir_wdata_nxt;
  logic bit_we_nxt;
  logic bit_wdata_nxt;

  // Result selection per form
  always_comb begin
    acc_we_nxt = 1'b0;
    acc_wdata_nxt = acc_in;
    carry_we_nxt = 1'b0;
    carry_wdata_nxt = carry_in;
    dir_we_nxt = 1'b0;
    dir_wdata_nxt = dir_val;
    bit_we_nxt = 1'b0;
    bit_wdata_nxt = bit_val;
    case (form)
      // [RULE1] Accumulator AND, no flag write
      LCCE_F_ANL_A_RN, LCCE_F_ANL_A_DIR, LCCE_F_ANL_A_IND, LCCE_F_ANL_A_IMM: begin
        acc_we_nxt = 1'b1;
        acc_wdata_nxt = anl_acc;
      end
      // [RULE6] Store back to direct
      LCCE_F_ANL_D_A, LCCE_F_ANL_D_IMM: begin
        dir_we_nxt = 1'b1;
        dir_wdata_nxt = anl_dir;
      end
      // [RULE8] Clear carry on zero source
      LCCE_F_ANL_C_BIT, LCCE_F_ANL_C_NB: begin
        carry_we_nxt = 1'b1;
        carry_wdata_nxt = carry_in & bit_src;
      end
      // [RULE13] Carry from compare
      LCCE_F_CJ_A_DIR, LCCE_F_CJ_A_IMM, LCCE_F_CJ_RN_IMM, LCCE_F_CJ_IN_IMM: begin
        carry_we_nxt = 1'b1;
        carry_wdata_nxt = cmp_lt;
      end
      // [RULE17] Zero accumulator
      LCCE_F_CLR_A: begin
        acc_we_nxt = 1'b1;
        acc_wdata_nxt = '0;
      end
      // [RULE18] Zero carry or bit
      LCCE_F_CLR_C: begin
        carry_we_nxt = 1'b1;
        carry_wdata_nxt = 1'b0;
      end
      LCCE_F_CLR_BIT: begin
        bit_we_nxt = 1'b1;
        bit_wdata_nxt = 1'b0;
      end
      // [RULE19] Invert accumulator
      LCCE_F_CPL_A: begin
        acc_we_nxt = 1'b1;
        acc_wdata_nxt = ~acc_in;
      end
      // [RULE20] Invert carry or bit
      LCCE_F_CPL_C: begin
        carry_we_nxt = 1'b1;
        carry_wdata_nxt = ~carry_in;
      end
      LCCE_F_CPL_BIT: begin
        bit_we_nxt = 1'b1;
        bit_wdata_nxt = ~bit_val;
      end
      default: begin
        acc_we_nxt = 1'b0;
      end
    endcase
  end

  // Start accepted only while idle; starts during a wait are ignored
  wire logic take = start && (state_r == LCCE_S_IDLE);
  wire logic two_cycle = (cycles == LCCE_CYC_2);

  // Pending result held over the extra cycle of two-cycle forms
  logic pend_acc_we_r;
  logic [DATA_W-1:0] pend_acc_r;
  logic pend_carry_we_r;
  logic pend_carry_r;
  logic pend_dir_we_r;
  logic [DATA_W-1:0] pend_dir_r;
  logic pend_bit_we_r;
  logic pend_bit_r;
  logic pend_branch_r;
  logic [PC_W-1:0] pend_pc_r;
  logic [7:0] pend_daddr_r;
  logic pend_conflict_r;

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // [RULE7] Second cycle for long forms
      LCCE_S_IDLE: if (take && legal && two_cycle) begin
        state_nxt = LCCE_S_WAIT;
      end
      LCCE_S_WAIT: state_nxt = LCCE_S_IDLE;
      default: state_nxt = LCCE_S_IDLE;
    endcase
  end

  // Completion strobe: first edge for one-cycle, second edge for two-cycle
  wire logic fin_now = take && !(legal && two_cycle);
  wire logic fin_wait = (state_r == LCCE_S_WAIT);

  // Direct address is the second byte except mask form carries it there too
  wire logic [7:0] daddr = byte2;

  // State and pending capture
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r <= LCCE_S_IDLE;
      pend_acc_we_r <= 1'b0;
      pend_acc_r <= '0;
      pend_carry_we_r <= 1'b0;
      pend_carry_r <= 1'b0;
      pend_dir_we_r <= 1'b0;
      pend_dir_r <= '0;
      pend_bit_we_r <= 1'b0;
      pend_bit_r <= 1'b0;
      pend_branch_r <= 1'b0;
      pend_pc_r <= LCCE_PC_RST;
      pend_daddr_r <= LCCE_BYTE_RST;
      pend_conflict_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        pend_acc_we_r <= acc_we_nxt;
        pend_acc_r <= acc_wdata_nxt;
        pend_carry_we_r <= carry_we_nxt;
        pend_carry_r <= carry_wdata_nxt;
        pend_dir_we_r <= dir_we_nxt;
        pend_dir_r <= dir_wdata_nxt;
        pend_bit_we_r <= bit_we_nxt;
        pend_bit_r <= bit_wdata_nxt;
        pend_branch_r <= take_branch;
        pend_pc_r <= take_branch ? pc_tgt : pc_seq;
        pend_daddr_r <= daddr;
        pend_conflict_r <= conflict;
      end
    end
  end

  // Output registers: strobes are one-cycle pulses with done, data holds
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      conflict_r <= 1'b0;
      acc_we_r <= 1'b0;
      acc_wdata_r <= '0;
      carry_we_r <= 1'b0;
      carry_wdata_r <= 1'b0;
      dir_we_r <= 1'b0;
      dir_addr_r <= LCCE_BYTE_RST;
      dir_wdata_r <= '0;
      bit_we_r <= 1'b0;
      bit_addr_r <= LCCE_BYTE_RST;
      bit_wdata_r <= 1'b0;
      branch_r <= 1'b0;
      pc_next_r <= LCCE_PC_RST;
    end else begin
      busy_r <= (state_nxt == LCCE_S_WAIT);
      done_r <= fin_now || fin_wait;
      if (fin_now) begin
        // One-cycle forms and illegal opcodes answer at once
        illegal_r <= !legal;
        conflict_r <= conflict;
        acc_we_r <= acc_we_nxt;
        acc_wdata_r <= acc_wdata_nxt;
        carry_we_r <= carry_we_nxt;
        carry_wdata_r <= carry_wdata_nxt;
        dir_we_r <= dir_we_nxt;
        dir_addr_r <= daddr;
        dir_wdata_r <= dir_wdata_nxt;
        bit_we_r <= bit_we_nxt;
        bit_addr_r <= daddr;
        bit_wdata_r <= bit_wdata_nxt;
        branch_r <= 1'b0;
        pc_next_r <= pc_seq;
      end else if (fin_wait) begin
        // Two-cycle forms release the held result
        illegal_r <= 1'b0;
        conflict_r <= pend_conflict_r;
        acc_we_r <= pend_acc_we_r;
        acc_wdata_r <= pend_acc_r;
        carry_we_r <= pend_carry_we_r;
        carry_wdata_r <= pend_carry_r;
        dir_we_r <= pend_dir_we_r;
        dir_addr_r <= pend_daddr_r;
        dir_wdata_r <= pend_dir_r;
        bit_we_r <= pend_bit_we_r;
        bit_addr_r <= pend_daddr_r;
        bit_wdata_r <= pend_bit_r;
        branch_r <= pend_branch_r;
        pc_next_r <= pend_pc_r;
      end else begin
        // Write strobes drop after their single cycle
        acc_we_r <= 1'b0;
        carry_we_r <= 1'b0;
        dir_we_r <= 1'b0;
        bit_we_r <= 1'b0;
        branch_r <= 1'b0;
      end
    end
  end

endmodule : lcce_exec

/* bench/lcce_exec_asserts.sv */
// Port-level timing and result checks for the execute unit
`timescale 1ns/1ps
module lcce_exec_asserts
  import lcce_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int PC_W = 16
) (
  input logic clk_sys,
  input logic reset_n,
  input logic start,
  input logic [7:0] opcode,
  input logic [7:0] byte2,
  input logic [7:0] byte3,
  input logic [PC_W-1:0] pc_in,
  input logic [DATA_W-1:0] acc_in,
  input logic carry_in,
  input logic [DATA_W-1:0] dir_pin_in,
  input logic [DATA_W-1:0] dir_latch_in,
  input logic dir_is_port,
  input logic bit_pin_in,
  input logic bit_latch_in,
  input logic bit_is_port,
  input logic busy_r,
  input logic done_r,
  input logic illegal_r,
  input logic acc_we_r,
  input logic [DATA_W-1:0] acc_wdata_r,
  input logic carry_we_r,
  input logic carry_wdata_r,
  input logic dir_we_r,
  input logic [DATA_W-1:0] dir_wdata_r,
  input logic bit_we_r,
  input logic branch_r,
  input logic [PC_W-1:0] pc_next_r
);
  // Original byte and bit, latch side for ports
  logic [DATA_W-1:0] dsrc;
  logic bsrc;
  assign dsrc = dir_is_port ? dir_latch_in : dir_pin_in;
  assign bsrc = bit_is_port ? bit_latch_in : bit_pin_in;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Request accepted only while not in a wait cycle
  sequence s_take(logic [7:0] op);
    start && !busy_r && opcode == op;
  endsequence
  // Two-cycle forms: one busy cycle, then done
  sequence s_wait;
    busy_r && !done_r ##1 done_r && !busy_r;
  endsequence

  AST_CLR_A: assert property (s_take(8'he4) |=> done_r && acc_we_r && acc_wdata_r == '0 && !carry_we_r)
    else $error("clear accumulator result wrong");
  AST_CPL_A: assert property (s_take(8'hf4) |=> acc_we_r && acc_wdata_r == ~$past(acc_in) && !carry_we_r)
    else $error("complement accumulator result wrong");
  AST_ANL_IMM: assert property (s_take(8'h54) |=> acc_wdata_r == ($past(acc_in) & $past(byte2))
    && pc_next_r == PC_W'($past(pc_in) + 2))
    else $error("and with immediate wrong");
  AST_ANL_MASK: assert property (s_take(8'h53) |=> s_wait ##0 dir_we_r
    && dir_wdata_r == ($past(dsrc, 2) & $past(byte3, 2)))
    else $error("direct mask and wrong");
  AST_CMP_DIR: assert property (s_take(8'hb5) |=> s_wait ##0 carry_we_r
    && carry_wdata_r == ($past(acc_in, 2) < $past(dsrc, 2)) && branch_r == ($past(acc_in, 2) != $past(dsrc, 2)))
    else $error("compare result wrong");
  AST_ANL_CBIT: assert property (s_take(8'h82) |=> s_wait ##0 carry_we_r
    && carry_wdata_r == ($past(carry_in, 2) & $past(bsrc, 2)))
    else $error("carry and bit wrong");
  AST_CLR_C: assert property (s_take(8'hc3) |=> carry_we_r && !carry_wdata_r
    && pc_next_r == PC_W'($past(pc_in) + 1))
    else $error("clear carry wrong");
  AST_CPL_C: assert property (s_take(8'hb3) |=> carry_we_r && carry_wdata_r == !$past(carry_in))
    else $error("complement carry wrong");
  AST_WE_DONE: assert property ((acc_we_r || carry_we_r || dir_we_r || bit_we_r || branch_r)
    |-> done_r && !illegal_r)
    else $error("write strobe outside a legal done");
endmodule : lcce_exec_asserts

bind lcce_exec lcce_exec_asserts #(.DATA_W(DATA_W), .PC_W(PC_W)) chk_u (.*);

/* bench/lcce_exec_tb.sv */
// Self-checking bench with reference model for the execute unit
`timescale 1ns/1ps
module lcce_exec_tb;
  import lcce_pkg::*;
  logic clk_sys, reset_n, start, carry_in, dir_is_port, bit_pin_in, bit_latch_in, bit_is_port;
  logic [7:0] opcode, byte2, byte3, acc_in, reg_in, ind_in, dir_pin_in, dir_latch_in;
  logic [15:0] pc_in, pc_next_r;
  logic busy_r, done_r, illegal_r, conflict_r, acc_we_r, carry_we_r, carry_wdata_r;
  logic dir_we_r, bit_we_r, bit_wdata_r, branch_r;
  logic [7:0] acc_wdata_r, dir_addr_r, dir_wdata_r, bit_addr_r;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 6951;

  lcce_exec #(.DATA_W(8), .PC_W(16)) dut_u (.*);

  // Free-running system clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Compare and count; four-state compare, X matches only X
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // One instruction: random operands, model, drive, compare
  task automatic run(input logic [7:0] op, input bit eq, input bit hold);
    logic [95:0] rv;
    logic [7:0] a, r, i, dp, dl, b2, b3, ea, ew, u, v, x;
    logic [15:0] pc, epc;
    logic c, bp, bl, ds, bs, ec, ewe, bwe, ebw, ebr, cmp, ill, cf, y;
    int n, ecyc, len;
    rv = {$random(seed), $random(seed), $random(seed)};
    {a, r, i, dp, dl, b2, b3, pc, c, bp, bl, ds, bs} = rv[76:0];
    // Equal operands reach the not-taken compare path
    if (eq) begin
      {r, i, dp, b2} = {4{a}};
    end
    // Plain reads see the same value on pin and latch
    if (op inside {8'h55, 8'hb5, 8'h82, 8'hb0}) begin
      {dl, bl} = {dp, bp};
    end
    x = ds ? dl : dp;
    y = bs ? bl : bp;
    {ea, ec, ewe, ew, bwe, ebw, ebr, cf, ill, cmp, u, v} = {a, c, 1'b0, 8'h00, 6'h00, 16'h0000};
    len = 1;
    ecyc = 1;
    case (op) inside
      [8'h58:8'h5f]: ea = a & r;
      8'h56, 8'h57: ea = a & i;
      8'h55: {ea, len} = {a & dp, 32'd2};
      8'h54: {ea, len} = {a & b2, 32'd2};
      8'h52: {ewe, ew, len} = {1'b1, x & a, 32'd2};
      8'h53: {ewe, ew, len, ecyc} = {1'b1, x & b3, 32'd3, 32'd2};
      8'h82: {ec, len, ecyc} = {c & y, 32'd2, 32'd2};
      8'hb0: {ec, cf, len, ecyc} = {c & ~y, 1'b1, 32'd2, 32'd2};
      8'hb5: {cmp, u, v} = {1'b1, a, dp};
      8'hb4: {cmp, u, v, cf} = {1'b1, a, b2, 1'b1};
      [8'hb8:8'hbf]: {cmp, u, v} = {1'b1, r, b2};
      8'hb6, 8'hb7: {cmp, u, v, cf} = {1'b1, i, b2, 1'b1};
      8'he4: ea = 8'h00;
      8'hc3: ec = 1'b0;
      8'hc2: {bwe, ebw, len} = {2'b10, 32'd2};
      8'hf4: ea = ~a;
      8'hb3: ec = ~c;
      8'hb2: {bwe, ebw, len} = {1'b1, ~y, 32'd2};
      default: ill = 1'b1;
    endcase
    if (cmp) begin
      {ec, ebr, len, ecyc} = {u < v, u != v, 32'd3, 32'd2};
    end
    epc = pc + len[15:0] + (ebr ? {{8{b3[7]}}, b3} : 16'h0000);
    @(posedge clk_sys);
    start <= 1'b1;
    opcode <= op;
    {byte2, byte3, pc_in, acc_in, carry_in, reg_in, ind_in} <= {b2, b3, pc, a, c, r, i};
    {dir_pin_in, dir_latch_in, dir_is_port, bit_pin_in, bit_latch_in, bit_is_port} <= {dp, dl, ds, bp, bl, bs};
    @(posedge clk_sys);
    // Held request during the wait cycle must be ignored
    start <= hold && ecyc == 2;
    n = 1;
    #1;
    while (done_r !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      n++;
    end
    check(n, ecyc);
    check(illegal_r, ill);
    check(acc_we_r ? acc_wdata_r : a, ea);
    check(carry_we_r ? carry_wdata_r : c, ec);
    check({dir_we_r, bit_we_r, branch_r}, {ewe, bwe, ebr});
    if (ewe) begin
      check({dir_addr_r, dir_wdata_r}, {b2, ew});
    end
    if (bwe) begin
      check({bit_addr_r, bit_wdata_r}, {b2, ebw});
    end
    check(pc_next_r, epc);
    check(conflict_r, cf);
  endtask : run

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #500000;
    n_errors++;
    close_out();
  end

  // Reset, then every opcode four times with varied operands
  initial begin
    {start, opcode, byte2, byte3, pc_in, acc_in, carry_in, reg_in, ind_in} = '0;
    {dir_pin_in, dir_latch_in, dir_is_port, bit_pin_in, bit_latch_in, bit_is_port} = '0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    check({busy_r, done_r, illegal_r, acc_we_r, carry_we_r, dir_we_r, bit_we_r, branch_r, pc_next_r}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      // Mid-run reset between passes must clear the status, write strobe, branch and PC outputs again
      if (s == 2) begin
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1;
        check({busy_r, done_r, illegal_r, acc_we_r, carry_we_r, dir_we_r, bit_we_r, branch_r, pc_next_r}, 32'h0);
      end
      for (int k = 0; k < 256; k++) begin
        run(k[7:0], s[0], s[1]);
      end
    end
    close_out();
  end
endmodule : lcce_exec_tb
